// ==== bench/omd_detect_asserts.sv ====
// concurrent checks on the ports of the limit and mismatch detector
`timescale 1ns/1ps
`include "omd_regs.vh"
module omd_detect_asserts (
   input wire clk,
   input wire sys_rst,
   input wire sample_valid,
   input wire [3:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_wdata,
   input wire [31:0] reg_rdata,
   input wire interrupt_line_second_n
);
   reg [23:0] vlim, ilim, mlim;
   reg [31:0] en;
   // shadows of the limit and enable registers, limits are not visible at the ports
   always @(posedge clk) begin
      if (sys_rst) begin
         vlim <= `OMD_RESET_VOLTAGE_LIMIT;
         ilim <= `OMD_RESET_CURRENT_LIMIT;
         mlim <= `OMD_RESET_MISMATCH_LIMIT;
         en <= 32'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            4'h0: vlim <= reg_wdata[23:0];
            4'h1: ilim <= reg_wdata[23:0];
            4'h3: mlim <= reg_wdata[23:0];
            4'h6: en <= reg_wdata;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_ov_hit; sample_valid && !reg_wr && en[18] && vlim == 24'h0; endsequence
   sequence s_oc_hit; sample_valid && !reg_wr && en[17] && ilim == 24'h0; endsequence
   sequence s_mm_hit; sample_valid && !reg_wr && en[20] && (mlim[23] || mlim == 24'h0); endsequence
   sequence s_clear_all;
      reg_wr && !sample_valid && reg_addr == 4'h5 && (&{reg_wdata[20], reg_wdata[18:17]});
   endsequence
   chk_ov_zero_limit: assert property (s_ov_hit |=> !interrupt_line_second_n)
      else $error("overvoltage at zero limit left line high");
   chk_oc_zero_limit: assert property (s_oc_hit |=> !interrupt_line_second_n)
      else $error("overcurrent at zero limit left line high");
   chk_mm_nonpositive: assert property (s_mm_hit |=> !interrupt_line_second_n)
      else $error("mismatch at non-positive limit left line high");
   chk_clear_release: assert property (s_clear_all |=> interrupt_line_second_n)
      else $error("line stayed low after full clear");
   chk_irq_needs_enable:
      assert property (!(en[20] || en[18] || en[17]) |-> interrupt_line_second_n)
      else $error("line low with no event enabled");
   chk_irq_sticky:
      assert property (!interrupt_line_second_n && !reg_wr |=> !interrupt_line_second_n)
      else $error("line released without a write");
   chk_full_scale_quiet:
      assert property (!en[20] && vlim >= `OMD_FULL_SCALE && ilim >= `OMD_FULL_SCALE
         && interrupt_line_second_n && !reg_wr |=> interrupt_line_second_n)
      else $error("event flagged at full scale limits");
   chk_mlim_sign_read:
      assert property (reg_rd && reg_addr == 4'h3
         |=> reg_rdata == {4'h0, {4{$past(mlim[23])}}, $past(mlim)})
      else $error("mismatch limit read not sign extended");
endmodule
bind omd_detect omd_detect_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
   .sample_valid(sample_valid), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .interrupt_line_second_n(interrupt_line_second_n));

// ==== bench/omd_host.sv ====
// host model issuing strobed accesses on the register port
`timescale 1ns/1ps
module omd_host (
   input wire clk,
   input wire [31:0] reg_rdata,
   output reg [3:0] reg_addr = 4'h0,
   output reg reg_wr = 1'b0,
   output reg reg_rd = 1'b0,
   output reg [31:0] reg_wdata = 32'h0
);
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      reg_wdata = ~d; // stale data never looks like a fresh word
   endtask
   task rd(input [3:0] a, output [31:0] d);
      @(posedge clk);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // status, then phase flags, then write-one clear
   task service(input [31:0] mask, output [31:0] st, output [31:0] ph);
      rd(4'h5, st);
      rd(4'h7, ph);
      wr(4'h5, mask);
   endtask
endmodule

// ==== bench/test_omd_detect.sv ====
// self-checking testbench of the limit and mismatch detector
`timescale 1ns/1ps
module test_omd_detect;
   reg clk = 1'b0, sys_rst = 1'b1, sample_valid = 1'b0;
   reg [23:0] va = 24'h0, vb = 24'h0, vc = 24'h0, ia = 24'h0, ib = 24'h0, ic = 24'h0, ni = 24'h0;
   wire [3:0] reg_addr;
   wire reg_wr, reg_rd, irq_n;
   wire [31:0] reg_wdata, reg_rdata;
   reg [31:0] st, ph, rv;
   integer n_errors = 0, n_tests = 0;
   always #50 clk = ~clk;
   omd_detect u_dut (.clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
      .phase_a_voltage_sample(va), .phase_b_voltage_sample(vb), .phase_c_voltage_sample(vc),
      .phase_a_current_sample(ia), .phase_b_current_sample(ib), .phase_c_current_sample(ic),
      .neutral_current_sample(ni), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .interrupt_line_second_n(irq_n));
   omd_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   task chk(input [31:0] seen, input [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task rchk(input [3:0] a, input [31:0] exp);
      u_host.rd(a, rv);
      chk(rv, exp);
   endtask
   task finish_test;
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task samp;
      @(posedge clk);
      #1 sample_valid = 1'b1;
      @(posedge clk);
      #1 sample_valid = 1'b0;
   endtask
   // phase b just above limit and negative, phase a exactly at limit
   task t_ov;
      chk(irq_n, 1);
      rchk(4'h0, 32'h005a7540);
      rchk(4'h3, 32'h0);
      u_host.wr(4'h3, 32'h007fffff);
      u_host.wr(4'h0, 32'h100);
      u_host.wr(4'h6, 32'h40000);
      va = 24'h000100;
      vb = 24'hfffeff;
      samp;
      chk(irq_n, 0);
      u_host.service(32'h40000, st, ph);
      chk(st, 32'h40000);
      chk(ph, 32'h400);
      chk(irq_n, 1);
      rchk(4'h7, 32'h0);
      rchk(4'h4, 32'h20000);
   endtask
   // voltages back under their limit, else the overvoltage flag sets again and fails the status check
   task t_oc;
      va = 24'h0;
      vb = 24'h0;
      u_host.wr(4'h1, 32'h200);
      u_host.wr(4'h6, 32'h20000);
      ia = 24'h000201;
      ib = 24'hfffeb0;
      ic = 24'hfffe00;
      samp;
      chk(irq_n, 0);
      u_host.service(32'h20000, st, ph);
      chk({st[20:17], ph[11:3]}, {4'h1, 9'h001});
      chk(irq_n, 1);
      rchk(4'h2, 32'h0ffffeb1);
   endtask
   // zero limits fire on every sample, full scale limits never
   task t_edges;
      u_host.wr(4'h0, 32'h0);
      u_host.wr(4'h1, 32'h0);
      u_host.wr(4'h6, 32'h60000);
      repeat (2) begin
         samp;
         chk(irq_n, 0);
         u_host.wr(4'h5, 32'h60000);
      end
      u_host.wr(4'h0, 32'h5a7540);
      u_host.wr(4'h1, 32'h5a7540);
      va = 24'h7fffff;
      samp;
      chk(irq_n, 1);
      rchk(4'h5, 32'h0);
   endtask
   task t_mm;
      u_host.wr(4'h6, 32'h100000);
      u_host.wr(4'h3, 32'hfffffe);
      rchk(4'h3, 32'h0ffffffe);
      samp;
      chk(irq_n, 0);
      u_host.wr(4'h5, 32'h160000);
      chk(irq_n, 1);
      u_host.wr(4'h3, 32'h100);
      ia = 24'h000300;
      ib = 24'h0;
      ic = 24'h0;
      ni = 24'hfffe00;
      samp;
      chk(irq_n, 1);
      ni = 24'h0001ff;
      samp;
      chk(irq_n, 0);
      rchk(4'h5, 32'h100000);
   endtask
   // reset in mid-run, then the rms estimate from each source and the ready clear
   task t_rst_rms;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      chk(irq_n, 1);
      rchk(4'h3, 32'h0);
      ia = 24'h012300;
      u_host.wr(4'h8, 32'h1);
      rchk(4'h8, 32'h1);
      samp;
      rchk(4'h5, 32'h100000);
      rchk(4'h9, 32'h123);
      u_host.wr(4'h8, 32'h0);
      samp;
      rchk(4'h9, 32'h123);
      u_host.wr(4'h4, 32'h20000);
      rchk(4'h4, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 sys_rst = 1'b0;
      t_ov;
      t_oc;
      t_edges;
      t_mm;
      t_rst_rms;
      finish_test;
   end
   initial begin
      #(2000 * 100);
      n_errors = n_errors + 1;
      finish_test;
   end
endmodule

// ==== logic/omd_detect.v ====
// overvoltage, overcurrent and neutral mismatch detector with its register file
`timescale 1ns/1ps
`include "omd_regs.vh"

module omd_detect (
   input wire clk,
   input wire sys_rst,
   input wire sample_valid,
   input wire [23:0] phase_a_voltage_sample,
   input wire [23:0] phase_b_voltage_sample,
   input wire [23:0] phase_c_voltage_sample,
   input wire [23:0] phase_a_current_sample,
   input wire [23:0] phase_b_current_sample,
   input wire [23:0] phase_c_current_sample,
   input wire [23:0] neutral_current_sample,
   input wire [3:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   output reg interrupt_line_second_n
);

   function [23:0] abs24;
      input [23:0] x;
      begin
         abs24 = x[23] ? (~x + 24'h000001) : x;
      end
   endfunction

   function [27:0] abs28;
      input [27:0] x;
      begin
         abs28 = x[27] ? (~x + 28'h0000001) : x;
      end
   endfunction

   // limit test shared by voltage and current channels
   function over_limit;
      input [23:0] mag;
      input [23:0] limit;
      begin
         if (limit >= `OMD_FULL_SCALE) begin
            over_limit = 1'b0;
         end else if (limit == 24'h000000) begin
            over_limit = 1'b1;
         end else begin
            over_limit = (mag > limit);
         end
      end
   endfunction

   // shared index decode, so no register can miss the write qualifier
   function write_hit;
      input wr;
      input [3:0] addr;
      input [3:0] idx;
      begin
         write_hit = wr & (addr == idx);
      end
   endfunction

   reg [23:0] voltage_limit;
   reg [23:0] current_limit;
   reg [23:0] mismatch_limit;
   reg [27:0] phase_current_total;
   reg sample_ready_flag;
   reg high_voltage_flag;
   reg excess_current_flag;
   reg neutral_mismatch_flag;
   reg [2:0] high_voltage_phase_bits;
   reg [2:0] excess_current_phase_bits;
   reg en_high_voltage;
   reg en_excess_current;
   reg en_neutral_mismatch;
   reg neutral_rms_source_select;
   reg [35:0] rms_acc;

   wire [23:0] volt [0:2];
   wire [23:0] curr [0:2];
   wire [2:0] volt_hit;
   wire [2:0] curr_hit;

   assign volt[0] = phase_a_voltage_sample;
   assign volt[1] = phase_b_voltage_sample;
   assign volt[2] = phase_c_voltage_sample;
   assign curr[0] = phase_a_current_sample;
   assign curr[1] = phase_b_current_sample;
   assign curr[2] = phase_c_current_sample;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_phase
         assign volt_hit[g] = sample_valid & over_limit(abs24(volt[g]), voltage_limit);
         assign curr_hit[g] = sample_valid & over_limit(abs24(curr[g]), current_limit);
      end
   endgenerate

   // sum of sign-extended phase currents
   wire [27:0] next_total;
   assign next_total = {{4{curr[0][23]}}, curr[0]} + {{4{curr[1][23]}}, curr[1]}
      + {{4{curr[2][23]}}, curr[2]};

   // mismatch compare on the fresh sum, not the stored one
   wire [27:0] total_mag;
   wire [27:0] neutral_mag;
   wire [27:0] diff_mag;
   wire [27:0] mismatch_limit_ext;
   wire mismatch_hit;
   assign total_mag = abs28(next_total);
   assign neutral_mag = {4'h0, abs24(neutral_current_sample)};
   assign diff_mag = (total_mag >= neutral_mag) ? (total_mag - neutral_mag)
      : (neutral_mag - total_mag);
   assign mismatch_limit_ext = {{4{mismatch_limit[23]}}, mismatch_limit};
   assign mismatch_hit = sample_valid & (mismatch_limit_ext[27]
      | (mismatch_limit_ext == 28'h0000000) | (diff_mag > mismatch_limit_ext));

   // write strobes; a clear and a new event in one cycle keep the event
   wire wr_voltage_limit;
   wire wr_current_limit;
   wire wr_mismatch_limit;
   wire wr_enable;
   wire wr_config;
   wire wr_first;
   wire wr_second;
   wire clr_ready;
   wire clr_high_voltage;
   wire clr_excess_current;
   wire clr_mismatch;
   assign wr_voltage_limit = write_hit(reg_wr, reg_addr, `OMD_ADDR_VOLTAGE_LIMIT);
   assign wr_current_limit = write_hit(reg_wr, reg_addr, `OMD_ADDR_CURRENT_LIMIT);
   assign wr_mismatch_limit = write_hit(reg_wr, reg_addr, `OMD_ADDR_MISMATCH_LIMIT);
   assign wr_enable = write_hit(reg_wr, reg_addr, `OMD_ADDR_INTERRUPT_ENABLE_SECOND);
   assign wr_config = write_hit(reg_wr, reg_addr, `OMD_ADDR_CONFIG);
   assign wr_first = write_hit(reg_wr, reg_addr, `OMD_ADDR_EVENT_FLAGS_FIRST);
   assign wr_second = write_hit(reg_wr, reg_addr, `OMD_ADDR_EVENT_FLAGS_SECOND);
   assign clr_ready = wr_first & reg_wdata[`OMD_BIT_SAMPLE_READY];
   assign clr_high_voltage = wr_second & reg_wdata[`OMD_BIT_HIGH_VOLTAGE];
   assign clr_excess_current = wr_second & reg_wdata[`OMD_BIT_EXCESS_CURRENT];
   assign clr_mismatch = wr_second & reg_wdata[`OMD_BIT_NEUTRAL_MISMATCH];

   reg next_high_voltage_flag;
   reg next_excess_current_flag;
   reg next_neutral_mismatch_flag;
   reg [2:0] next_high_voltage_phase_bits;
   reg [2:0] next_excess_current_phase_bits;
   reg next_en_high_voltage;
   reg next_en_excess_current;
   reg next_en_neutral_mismatch;

   always @* begin
      next_high_voltage_flag = (high_voltage_flag & ~clr_high_voltage) | (|volt_hit);
      next_high_voltage_phase_bits = (clr_high_voltage ? 3'h0 : high_voltage_phase_bits)
         | volt_hit;
      next_excess_current_flag = (excess_current_flag & ~clr_excess_current)
         | (|curr_hit);
      next_excess_current_phase_bits = (clr_excess_current ? 3'h0 : excess_current_phase_bits)
         | curr_hit;
      next_neutral_mismatch_flag = (neutral_mismatch_flag & ~clr_mismatch)
         | mismatch_hit;
      next_en_high_voltage = en_high_voltage;
      next_en_excess_current = en_excess_current;
      next_en_neutral_mismatch = en_neutral_mismatch;
      if (wr_enable) begin
         next_en_high_voltage = reg_wdata[`OMD_BIT_HIGH_VOLTAGE];
         next_en_excess_current = reg_wdata[`OMD_BIT_EXCESS_CURRENT];
         next_en_neutral_mismatch = reg_wdata[`OMD_BIT_NEUTRAL_MISMATCH];
      end
   end

   // neutral rms estimate: leaky average of the magnitude, a cheap stand-in for a true rms
   wire [35:0] rms_in;
   wire [35:0] next_rms_acc;
   assign rms_in = neutral_rms_source_select ? {8'h00, total_mag}
      : {8'h00, neutral_mag};
   assign next_rms_acc = rms_acc - (rms_acc >> `OMD_RMS_SHIFT) + rms_in;

   always @(posedge clk) begin
      if (sys_rst) begin
         voltage_limit <= `OMD_RESET_VOLTAGE_LIMIT;
         current_limit <= `OMD_RESET_CURRENT_LIMIT;
         mismatch_limit <= `OMD_RESET_MISMATCH_LIMIT;
         neutral_rms_source_select <= 1'b0;
         phase_current_total <= 28'h0000000;
         sample_ready_flag <= 1'b0;
         high_voltage_flag <= 1'b0;
         excess_current_flag <= 1'b0;
         neutral_mismatch_flag <= 1'b0;
         high_voltage_phase_bits <= 3'h0;
         excess_current_phase_bits <= 3'h0;
         en_high_voltage <= 1'b0;
         en_excess_current <= 1'b0;
         en_neutral_mismatch <= 1'b0;
         rms_acc <= 36'h000000000;
         interrupt_line_second_n <= 1'b1;
      end else begin
         if (wr_voltage_limit) begin
            voltage_limit <= reg_wdata[23:0];
         end
         if (wr_current_limit) begin
            current_limit <= reg_wdata[23:0];
         end
         // the host is expected to load a positive level after reset
         if (wr_mismatch_limit) begin
            mismatch_limit <= reg_wdata[23:0];
         end
         if (wr_config) begin
            neutral_rms_source_select <= reg_wdata[`OMD_BIT_NEUTRAL_RMS_SOURCE_SELECT];
         end
         if (sample_valid) begin
            phase_current_total <= next_total;
            rms_acc <= next_rms_acc;
         end
         sample_ready_flag <= (sample_ready_flag & ~clr_ready) | sample_valid;
         high_voltage_flag <= next_high_voltage_flag;
         excess_current_flag <= next_excess_current_flag;
         neutral_mismatch_flag <= next_neutral_mismatch_flag;
         high_voltage_phase_bits <= next_high_voltage_phase_bits;
         excess_current_phase_bits <= next_excess_current_phase_bits;
         en_high_voltage <= next_en_high_voltage;
         en_excess_current <= next_en_excess_current;
         en_neutral_mismatch <= next_en_neutral_mismatch;
         // follows the next flag values so the line moves with the flag
         interrupt_line_second_n <= ~((next_high_voltage_flag & next_en_high_voltage)
            | (next_excess_current_flag & next_en_excess_current)
            | (next_neutral_mismatch_flag & next_en_neutral_mismatch));
      end
   end

   // read data, one cycle after the read strobe; unmapped indices read zero
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = 32'h00000000;
      case (reg_addr)
         `OMD_ADDR_VOLTAGE_LIMIT: begin
            next_rdata = {8'h00, voltage_limit};
         end
         `OMD_ADDR_CURRENT_LIMIT: begin
            next_rdata = {8'h00, current_limit};
         end
         `OMD_ADDR_PHASE_CURRENT_TOTAL: begin
            next_rdata = {4'h0, phase_current_total};
         end
         `OMD_ADDR_MISMATCH_LIMIT: begin
            next_rdata = {4'h0, mismatch_limit_ext};
         end
         `OMD_ADDR_EVENT_FLAGS_FIRST: begin
            next_rdata[`OMD_BIT_SAMPLE_READY] = sample_ready_flag;
         end
         `OMD_ADDR_EVENT_FLAGS_SECOND: begin
            next_rdata[`OMD_BIT_HIGH_VOLTAGE] = high_voltage_flag;
            next_rdata[`OMD_BIT_EXCESS_CURRENT] = excess_current_flag;
            next_rdata[`OMD_BIT_NEUTRAL_MISMATCH] = neutral_mismatch_flag;
         end
         `OMD_ADDR_INTERRUPT_ENABLE_SECOND: begin
            next_rdata[`OMD_BIT_HIGH_VOLTAGE] = en_high_voltage;
            next_rdata[`OMD_BIT_EXCESS_CURRENT] = en_excess_current;
            next_rdata[`OMD_BIT_NEUTRAL_MISMATCH] = en_neutral_mismatch;
         end
         `OMD_ADDR_PER_PHASE_FLAGS: begin
            next_rdata[`OMD_POS_HIGH_VOLTAGE_PHASE +: 3] = high_voltage_phase_bits;
            next_rdata[`OMD_POS_EXCESS_CURRENT_PHASE +: 3] = excess_current_phase_bits;
         end
         `OMD_ADDR_CONFIG: begin
            next_rdata[`OMD_BIT_NEUTRAL_RMS_SOURCE_SELECT] = neutral_rms_source_select;
         end
         `OMD_ADDR_NEUTRAL_RMS_RESULT: begin
            next_rdata = {8'h00, rms_acc[31:8]};
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

// ==== logic/omd_regs.vh ====
// register indices, field positions and reset values of the limit and mismatch detector
`ifndef OMD_REGS_VH
`define OMD_REGS_VH

// register indices on the parallel register port
`define OMD_ADDR_VOLTAGE_LIMIT 4'h0
`define OMD_ADDR_CURRENT_LIMIT 4'h1
`define OMD_ADDR_PHASE_CURRENT_TOTAL 4'h2
`define OMD_ADDR_MISMATCH_LIMIT 4'h3
`define OMD_ADDR_EVENT_FLAGS_FIRST 4'h4
`define OMD_ADDR_EVENT_FLAGS_SECOND 4'h5
`define OMD_ADDR_INTERRUPT_ENABLE_SECOND 4'h6
`define OMD_ADDR_PER_PHASE_FLAGS 4'h7
`define OMD_ADDR_CONFIG 4'h8
`define OMD_ADDR_NEUTRAL_RMS_RESULT 4'h9

// first event flag register
`define OMD_BIT_SAMPLE_READY 17

// second event flag and interrupt enable registers
`define OMD_BIT_EXCESS_CURRENT 17
`define OMD_BIT_HIGH_VOLTAGE 18
`define OMD_BIT_NEUTRAL_MISMATCH 20

// per-phase flag register, phase a in the low bit of each field
`define OMD_POS_HIGH_VOLTAGE_PHASE 9
`define OMD_POS_EXCESS_CURRENT_PHASE 3

// configuration register
`define OMD_BIT_NEUTRAL_RMS_SOURCE_SELECT 0

// limits and reset values
`define OMD_FULL_SCALE 24'h5a7540
`define OMD_RESET_VOLTAGE_LIMIT 24'h5a7540
`define OMD_RESET_CURRENT_LIMIT 24'h5a7540
`define OMD_RESET_MISMATCH_LIMIT 24'h000000

// averaging shift of the neutral rms estimate
`define OMD_RMS_SHIFT 8

`endif
